//--- rtl/sem_host.sv
// Host controller for one port of a dual-port memory's semaphore flags.
// Assumes the pins go straight to the device port; data pins are split into in, out and enable.
`timescale 1ns/1ns
`default_nettype none
module sem_host
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  input wire sem_host_pkg::cmd_type req_cmd_i,
  input wire logic [sem_host_pkg::INDEX_WIDTH-1:0] req_index_i,
  input wire logic req_value_i,
  output logic req_ready_o,
  output logic done_o,
  output logic flag_o,
  output logic granted_o,
  output logic lines_agree_o,
  output logic semaphore_select_n_o,
  output logic chip_enable_n_o,
  output logic upper_lane_select_n_o,
  output logic lower_lane_select_n_o,
  output logic read_write_o,
  output logic output_enable_n_o,
  output logic [sem_host_pkg::INDEX_WIDTH-1:0] addr_o,
  input wire logic [sem_host_pkg::DATA_WIDTH-1:0] data_i,
  output logic [sem_host_pkg::DATA_WIDTH-1:0] data_o,
  output logic data_oe_o
);

  typedef struct packed
  {
    sem_host_pkg::state_type state;
    logic [sem_host_pkg::CNT_WIDTH-1:0] cnt;
    sem_host_pkg::cmd_type cmd;
    logic [sem_host_pkg::INDEX_WIDTH-1:0] index;
    logic wvalue;
    logic done;
    logic flag;
    logic granted;
    logic agree;
    logic sel_n;
    logic rw;
    logic oe_n;
    logic doe;
  } host_type;

  host_type cur_ff;
  host_type nxt_ff;

  sem_sync_if #(.WIDTH(sem_host_pkg::DATA_WIDTH)) data_sync ();

  assign data_sync.raw = data_i;

  sem_in_sync #(.WIDTH(sem_host_pkg::DATA_WIDTH)) u_data_sync
  (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .port(data_sync.sync_side)
  );

  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.done = 1'b0;
    unique case (cur_ff.state)
      sem_host_pkg::ST_IDLE:
      begin
        if (req_valid_i)
        begin
          nxt_ff.cmd = req_cmd_i;
          nxt_ff.index = req_index_i;
          unique case (req_cmd_i)
            sem_host_pkg::CMD_ACQUIRE: nxt_ff.wvalue = sem_host_pkg::FLAG_CLAIM;
            sem_host_pkg::CMD_RELEASE: nxt_ff.wvalue = sem_host_pkg::FLAG_FREE;
            default: nxt_ff.wvalue = req_value_i;
          endcase
          if (req_cmd_i == sem_host_pkg::CMD_READ)
          begin
            nxt_ff.state = sem_host_pkg::ST_READ;
            nxt_ff.cnt = 4'(sem_host_pkg::READ_WAIT_CYC);
          end
          else
          begin
            nxt_ff.state = sem_host_pkg::ST_SETUP;
          end
        end
      end
      sem_host_pkg::ST_SETUP:
      begin
        nxt_ff.state = sem_host_pkg::ST_WLOW;
        nxt_ff.cnt = 4'(sem_host_pkg::WRITE_PULSE_CYC);
      end
      sem_host_pkg::ST_WLOW:
      begin
        if (cur_ff.cnt == sem_host_pkg::CNT_ONE)
        begin
          nxt_ff.state = sem_host_pkg::ST_WEND;
        end
        else
        begin
          nxt_ff.cnt = cur_ff.cnt - sem_host_pkg::CNT_ONE;
        end
      end
      sem_host_pkg::ST_WEND:
      begin
        // Select stays low for the cycle that read/write rises
        nxt_ff.state = sem_host_pkg::ST_GAP;
        nxt_ff.cnt = 4'(sem_host_pkg::GAP_CYC);
      end
      sem_host_pkg::ST_GAP:
      begin
        if (cur_ff.cnt > sem_host_pkg::CNT_ONE)
        begin
          nxt_ff.cnt = cur_ff.cnt - sem_host_pkg::CNT_ONE;
        end
        else if (cur_ff.cmd == sem_host_pkg::CMD_ACQUIRE)
        begin
          // Read back to learn whether the claim won
          nxt_ff.state = sem_host_pkg::ST_READ;
          nxt_ff.cnt = 4'(sem_host_pkg::READ_WAIT_CYC);
        end
        else
        begin
          nxt_ff.state = sem_host_pkg::ST_IDLE;
          nxt_ff.done = 1'b1;
        end
      end
      sem_host_pkg::ST_READ:
      begin
        // Longer of access time and busy delay, plus synchroniser latency
        if (cur_ff.cnt == sem_host_pkg::CNT_ONE)
        begin
          nxt_ff.state = sem_host_pkg::ST_SAMPLE;
        end
        else
        begin
          nxt_ff.cnt = cur_ff.cnt - sem_host_pkg::CNT_ONE;
        end
      end
      sem_host_pkg::ST_SAMPLE:
      begin
        nxt_ff.flag = data_sync.stable[0];
        nxt_ff.agree = (&data_sync.stable) | ~(|data_sync.stable);
        nxt_ff.granted = (cur_ff.cmd == sem_host_pkg::CMD_ACQUIRE) &&
                         (data_sync.stable[0] == sem_host_pkg::FLAG_CLAIM);
        nxt_ff.state = sem_host_pkg::ST_IDLE;
        nxt_ff.done = 1'b1;
      end
      default:
      begin
        nxt_ff.state = sem_host_pkg::ST_IDLE;
      end
    endcase
    // Pin levels follow the next state so they leave flip-flops
    nxt_ff.sel_n = !(nxt_ff.state == sem_host_pkg::ST_SETUP || nxt_ff.state == sem_host_pkg::ST_WLOW ||
                     nxt_ff.state == sem_host_pkg::ST_WEND || nxt_ff.state == sem_host_pkg::ST_READ ||
                     nxt_ff.state == sem_host_pkg::ST_SAMPLE);
    nxt_ff.rw = (nxt_ff.state != sem_host_pkg::ST_WLOW);
    nxt_ff.oe_n = !(nxt_ff.state == sem_host_pkg::ST_READ ||
                    nxt_ff.state == sem_host_pkg::ST_SAMPLE);
    nxt_ff.doe = (nxt_ff.state == sem_host_pkg::ST_SETUP || nxt_ff.state == sem_host_pkg::ST_WLOW ||
                  nxt_ff.state == sem_host_pkg::ST_WEND);
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cur_ff <= '{state: sem_host_pkg::ST_IDLE, cmd: sem_host_pkg::CMD_READ, cnt: sem_host_pkg::CNT_ZERO,
                  index: '0, wvalue: 1'b0, done: 1'b0, flag: 1'b0, granted: 1'b0, agree: 1'b0,
                  sel_n: 1'b1, rw: 1'b1, oe_n: 1'b1, doe: 1'b0};
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign req_ready_o = (cur_ff.state == sem_host_pkg::ST_IDLE);
  assign done_o = cur_ff.done;
  assign flag_o = cur_ff.flag;
  assign granted_o = cur_ff.granted;
  assign lines_agree_o = cur_ff.agree;
  assign semaphore_select_n_o = cur_ff.sel_n;
  // Memory array kept unselected at all times
  assign chip_enable_n_o = 1'b1;
  assign upper_lane_select_n_o = 1'b1;
  assign lower_lane_select_n_o = 1'b1;
  assign read_write_o = cur_ff.rw;
  assign output_enable_n_o = cur_ff.oe_n;
  assign addr_o = cur_ff.index;
  // Value on every line; the device keeps only line zero
  assign data_o = {sem_host_pkg::DATA_WIDTH{cur_ff.wvalue}};
  assign data_oe_o = cur_ff.doe;

endmodule : sem_host
`default_nettype wire

//--- rtl/sem_host_pkg.sv
// Constants for the semaphore-port host controller.
// Assumes a 100 MHz system clock; all pin timings are converted to cycles here.
package sem_host_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int FLAG_COUNT = 8;
  localparam int INDEX_WIDTH = 3;
  localparam int DATA_WIDTH = 18;

  // Pin timing figures in ns (slower grade, so both grades are met)
  localparam int WRITE_PULSE_NS = 15;
  localparam int SEM_ADDR_ACCESS_NS = 20;
  localparam int BUSY_RELEASE_TO_DATA_DELAY_NS = 17;
  localparam int UPDATE_PULSE_NS = 10;
  localparam int WRITE_TO_READ_NS = 5;

  // Least times, rounded up to whole cycles, at least one
  function automatic int min_cycles(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : min_cycles

  localparam int WRITE_PULSE_CYC = min_cycles(WRITE_PULSE_NS);
  localparam int ACCESS_NS = (SEM_ADDR_ACCESS_NS > BUSY_RELEASE_TO_DATA_DELAY_NS) ?
                             SEM_ADDR_ACCESS_NS : BUSY_RELEASE_TO_DATA_DELAY_NS;
  localparam int ACCESS_CYC = min_cycles(ACCESS_NS);
  localparam int GAP_NS = (UPDATE_PULSE_NS > WRITE_TO_READ_NS) ? UPDATE_PULSE_NS : WRITE_TO_READ_NS;
  localparam int GAP_CYC = min_cycles(GAP_NS);
  // Input synchroniser: three stages plus the agreement register
  localparam int SYNC_LATENCY_CYC = 4;
  localparam int READ_WAIT_CYC = ACCESS_CYC + SYNC_LATENCY_CYC;

  localparam int CNT_WIDTH = 4;
  localparam logic [CNT_WIDTH-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_WIDTH-1:0] CNT_ONE = 4'h1;

  typedef enum logic [1:0]
  {
    CMD_READ = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_ACQUIRE = 2'h2,
    CMD_RELEASE = 2'h3
  } cmd_type;

  // Gray order along write, gap, read, sample
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_WLOW = 3'h3,
    ST_WEND = 3'h2,
    ST_GAP = 3'h6,
    ST_READ = 3'h7,
    ST_SAMPLE = 3'h5
  } state_type;

  // Flag written to claim a semaphore, and value that means granted
  localparam logic FLAG_CLAIM = 1'h0;
  localparam logic FLAG_FREE = 1'h1;

endpackage : sem_host_pkg

//--- rtl/sem_sync_if.sv
// Carrier between the host core and its input synchroniser.
// Assumes both ends share sys_clk_i.
`timescale 1ns/1ns
`default_nettype none
interface sem_sync_if #(parameter int WIDTH = 18);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] stable;
  modport sync_side (input raw, output stable);
  modport user_side (output raw, input stable);
endinterface : sem_sync_if
`default_nettype wire

//--- rtl/sem_in_sync.sv
// Three-stage synchroniser for pins read by the host.
// Assumes asynchronous pin levels; a change is taken once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module sem_in_sync #(parameter int WIDTH = 18)
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  sem_sync_if.sync_side port
);

  typedef struct packed
  {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } sync_type;

  sync_type cur_ff;
  sync_type nxt_ff;

  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.s1 = port.raw;
    nxt_ff.s2 = cur_ff.s1;
    nxt_ff.s3 = cur_ff.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (cur_ff.s2[i] == cur_ff.s3[i])
      begin
        nxt_ff.stable[i] = cur_ff.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign port.stable = cur_ff.stable;

endmodule : sem_in_sync
`default_nettype wire

//--- tb/sem_host_checker.sv
// Pin-level assertions for the semaphore host.
// Bound to sem_host; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module sem_host_checker
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic req_ready_o,
  input wire logic done_o,
  input wire logic semaphore_select_n_o,
  input wire logic chip_enable_n_o,
  input wire logic upper_lane_select_n_o,
  input wire logic lower_lane_select_n_o,
  input wire logic read_write_o,
  input wire logic output_enable_n_o,
  input wire logic [sem_host_pkg::INDEX_WIDTH-1:0] addr_o,
  input wire logic [sem_host_pkg::DATA_WIDTH-1:0] data_o,
  input wire logic data_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  mem_unsel_a:
    assert property (chip_enable_n_o && upper_lane_select_n_o && lower_lane_select_n_o) else $error("memory selected");
  wdata_rep_a:
    assert property (data_oe_o |-> data_o == {sem_host_pkg::DATA_WIDTH{data_o[0]}}) else $error("write lines differ");
  read_pins_a:
    assert property (!output_enable_n_o |-> read_write_o && !semaphore_select_n_o && !data_oe_o)
    else $error("bad read pins");
  write_pins_a:
    assert property (!read_write_o |-> !semaphore_select_n_o && data_oe_o && output_enable_n_o)
    else $error("bad write pins");
  write_pulse_a:
    assert property ($fell(read_write_o) |-> ##1 !read_write_o ##1 read_write_o && !semaphore_select_n_o)
    else $error("bad write pulse");
  update_gap_a:
    assert property ($rose(read_write_o) |=> semaphore_select_n_o) else $error("no gap after write");
  read_len_a:
    assert property ($fell(output_enable_n_o) |-> !output_enable_n_o [*7] ##1 output_enable_n_o)
    else $error("bad read length");
  addr_hold_a:
    assert property (!semaphore_select_n_o && !$fell(semaphore_select_n_o) |-> $stable(addr_o))
    else $error("address moved");
  done_idle_a:
    assert property (done_o |-> req_ready_o && semaphore_select_n_o && output_enable_n_o)
    else $error("pins busy at done");
endmodule : sem_host_checker
bind sem_host sem_host_checker sem_host_checker_inst(.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .req_ready_o(req_ready_o), .done_o(done_o), .semaphore_select_n_o(semaphore_select_n_o),
  .chip_enable_n_o(chip_enable_n_o), .upper_lane_select_n_o(upper_lane_select_n_o),
  .lower_lane_select_n_o(lower_lane_select_n_o), .read_write_o(read_write_o),
  .output_enable_n_o(output_enable_n_o), .addr_o(addr_o), .data_o(data_o), .data_oe_o(data_oe_o));
`default_nettype wire

//--- tb/sem_flag_model.sv
// Behavioural model of the device's eight semaphore flags, one port.
// Assumes the host pins are wired straight in.
`timescale 1ns/1ns
`default_nettype none
module sem_flag_model
(
  input wire logic semaphore_select_n_i,
  input wire logic ce_n_i,
  input wire logic upper_lane_select_n_i,
  input wire logic lower_lane_select_n_i,
  input wire logic rw_i,
  input wire logic oe_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [17:0] wdata_i,
  output logic [17:0] rdata_o
);
  logic [7:0] flag_ff = 8'hff;
  logic [17:0] last = 18'h0_0000;
  wire logic unsel;
  wire logic rd;
  wire logic rd_d;
  wire logic [2:0] addr_d;
  assign unsel = ce_n_i || (upper_lane_select_n_i && lower_lane_select_n_i);
  assign rd = !semaphore_select_n_i && rw_i && !oe_n_i && unsel;
  assign #20 rd_d = rd;
  assign #20 addr_d = addr_i;
  always @(posedge rw_i)
    if (!semaphore_select_n_i && unsel)
      flag_ff[addr_i] <= wdata_i[0];
  always @*
    if (rd && rd_d && addr_d == addr_i)
      last = {18{flag_ff[addr_i]}};
  // Released lines show the inverse of the last value
  assign rdata_o = (rd && rd_d && addr_d == addr_i) ? last : ~last;
endmodule : sem_flag_model
`default_nettype wire

//--- tb/sem_host_tb_top.sv
// Self-checking bench for sem_host against the flag model.
// Assumes the package, checker and model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module sem_host_tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  sem_host_pkg::cmd_type req_cmd = sem_host_pkg::CMD_READ;
  logic [2:0] req_index = 3'h0;
  logic req_value = 1'b0;
  logic req_ready, done, flag, granted, agree, select_n, ce_n, upper_n, lower_n, rw, oe_n, data_oe;
  logic [2:0] addr;
  logic [17:0] rdata;
  logic [17:0] wdata;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      stop_test();
    end
  end
  sem_host sem_host_inst(.sys_clk_i(sys_clk), .reset_i(reset), .req_valid_i(req_valid), .req_cmd_i(req_cmd),
    .req_index_i(req_index), .req_value_i(req_value), .req_ready_o(req_ready), .done_o(done), .flag_o(flag),
    .granted_o(granted), .lines_agree_o(agree), .semaphore_select_n_o(select_n), .chip_enable_n_o(ce_n),
    .upper_lane_select_n_o(upper_n), .lower_lane_select_n_o(lower_n), .read_write_o(rw),
    .output_enable_n_o(oe_n), .addr_o(addr), .data_i(rdata), .data_o(wdata), .data_oe_o(data_oe));
  sem_flag_model sem_flag_model_inst(.semaphore_select_n_i(select_n), .ce_n_i(ce_n),
    .upper_lane_select_n_i(upper_n), .lower_lane_select_n_i(lower_n),
    .rw_i(rw), .oe_n_i(oe_n), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata));
  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit
  // Issues one request; called just after an edge, back to back after done
  task automatic do_op(input sem_host_pkg::cmd_type cmd, input logic [2:0] idx, input logic val);
    int n;
    check_bit(req_ready, 1'b1);
    req_cmd = cmd;
    req_index = idx;
    req_value = val;
    req_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check_bit(done, 1'b1);
  endtask : do_op
  task automatic test_flags();
    for (int i = 0; i < 8; i++)
      do_op(sem_host_pkg::CMD_WRITE, 3'(i), 1'(i ^ (i >> 1)));
    for (int i = 0; i < 8; i++)
    begin
      do_op(sem_host_pkg::CMD_READ, 3'(i), 1'b0);
      check_bit(flag, 1'(i ^ (i >> 1)));
      check_bit(agree, 1'b1);
    end
    $display("test_flags done");
  endtask : test_flags
  task automatic test_acquire();
    do_op(sem_host_pkg::CMD_RELEASE, 3'h5, 1'b0);
    do_op(sem_host_pkg::CMD_ACQUIRE, 3'h5, 1'b0);
    check_bit(granted, 1'b1);
    check_bit(flag, 1'b0);
    do_op(sem_host_pkg::CMD_READ, 3'h5, 1'b0);
    check_bit(granted, 1'b0);
    do_op(sem_host_pkg::CMD_RELEASE, 3'h5, 1'b0);
    do_op(sem_host_pkg::CMD_READ, 3'h5, 1'b0);
    check_bit(flag, 1'b1);
    check_bit(agree, 1'b1);
    $display("test_acquire done");
  endtask : test_acquire
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (16) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    @(posedge sys_clk);
    #1;
    test_flags();
    test_acquire();
    stop_test();
  end
endmodule : sem_host_tb_top
`default_nettype wire
